// file: core/opm_pkg.sv
// Purpose: constants shared by the output mode pin multiplexer
// Assumes: 8-bit configuration addresses and data, 4-bit register fields
// Notes: analog probe levels are carried as single logic bits
`default_nettype none
package opm_pkg;
  // configuration register addresses
  localparam logic [7:0] OPM_ADDR_TRIM = 8'h01;
  localparam logic [7:0] OPM_ADDR_MODE = 8'h02;
  // field layout: both registers use bits 3:0
  localparam int OPM_FIELD_LSB = 0;
  localparam int OPM_FIELD_MSB = 3;
  // reset values
  localparam logic [3:0] OPM_TRIM_RESET = 4'h0;
  localparam logic [3:0] OPM_MODE_RESET = 4'h0;
  // operating mode codes
  localparam logic [3:0] OPM_MODE_ABZ = 4'h0;
  localparam logic [3:0] OPM_MODE_CAL1 = 4'h1;
  localparam logic [3:0] OPM_MODE_CAL2 = 4'h2;
  localparam logic [3:0] OPM_MODE_TEST5 = 4'h5;
  localparam logic [3:0] OPM_MODE_TEST6 = 4'h6;
  localparam logic [3:0] OPM_MODE_CAL3 = 4'h7;
  localparam logic [3:0] OPM_MODE_SYSTEST = 4'hB;
  localparam logic [3:0] OPM_MODE_UVW = 4'hE;
  localparam logic [3:0] OPM_MODE_COUNTER = 4'hF;
  // warning threshold trim: 100 % at code zero, 5 % per step
  localparam logic [7:0] OPM_TRIM_BASE_PCT = 8'h64;
  localparam logic [7:0] OPM_TRIM_STEP_PCT = 8'h05;
  // shutdown lies this many millivolts beyond the warning threshold
  localparam logic [9:0] OPM_SHUTDOWN_DELTA_MV = 10'h019;
endpackage : opm_pkg
`default_nettype wire

// file: core/opm_temp_alarm.sv
// Purpose: temperature warning comparator with trimmed threshold
// Assumes: sense and reference given as millivolt codes below the supply
// Notes: sense voltage falls as the die heats up
`default_nettype none
module opm_temp_alarm (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // trim and measured levels
  input wire logic [3:0] trim,
  input wire logic [9:0] sense_mv,
  input wire logic [9:0] base_mv,
  // result
  output logic warn_window
);
  import opm_pkg::*;

  // compare in percent units to avoid a divider
  logic [7:0] pct;
  logic [19:0] thr_x100;
  logic [19:0] shut_x100;
  logic [19:0] sense_x100;
  logic [19:0] delta_x100;
  logic reached_warn;
  logic passed_shutdown;

  assign pct = OPM_TRIM_BASE_PCT + 8'(OPM_TRIM_STEP_PCT * trim);
  // widen before multiplying: a product sized to its operands would wrap
  assign thr_x100 = 20'(base_mv) * 20'(pct);
  assign sense_x100 = 20'(sense_mv) * 20'(OPM_TRIM_BASE_PCT);
  assign delta_x100 = 20'(OPM_SHUTDOWN_DELTA_MV) * 20'(OPM_TRIM_BASE_PCT);
  assign shut_x100 = thr_x100 - delta_x100;
  assign reached_warn = sense_x100 <= thr_x100;
  // a threshold below the shutdown delta means shutdown is never reached
  assign passed_shutdown = (thr_x100 >= delta_x100) && (sense_x100 < shut_x100);

  // high only between warning and shutdown
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      warn_window <= 1'b0;
    end else begin
      warn_window <= reached_warn && !passed_shutdown;
    end
  end
endmodule : opm_temp_alarm
`default_nettype wire

// file: core/opm_output_mux.sv
// Purpose: operating mode selector for the six output pins and alarm pin
// Assumes: all sources synchronous to clock; probe levels as logic bits
// Notes: pins are output/enable pairs; the pad resolves the wire
//
// Contract
// - a 4-bit mode field selects the function of six outputs and alarm
// - mode 0x00 drives complementary pairs carrying A, B and Z
// - mode 0x0E drives A B Z on positive pins, U V W on negative
// - mode 0x0F drives the six external counter control signals
// - line drivers and polarity protection only on in the three normal modes
// - calibration and test modes keep drivers off and present probes
// - codes 0x01, 0x02, 0x07 route calibration probes to the outputs
// - 0x05 conditioned signals plus internal error, 0x06 inputs, 0x0B digital cal
// - in mode 0x07 alarm drives low at warning threshold, releases past shutdown threshold
// - trim scales warning threshold 100 % plus 5 % per code
// - temperature calibration shows sense on a_pos, threshold on a_neg
// - in mode 0x00 the negative pin of a pair is the inverse of the positive
`default_nettype none
module opm_output_mux (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration port
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_write,
  input wire logic cfg_read,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // position and counter sources
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic quad_z,
  input wire logic comm_u,
  input wire logic comm_v,
  input wire logic comm_w,
  input wire logic count_down_pulse,
  input wire logic count_up_pulse,
  input wire logic count_pulse,
  input wire logic count_direction_low_up,
  input wire logic counter_clear_high,
  input wire logic counter_load_low,
  input wire logic error_active,
  input wire logic internal_error,
  // probe sources, 0 to 5 in pin order a_pos, a_neg, b_pos, b_neg, z_pos, z_neg
  input wire logic [5:0] probe_cal1,
  input wire logic [5:0] probe_cal2,
  input wire logic [5:0] probe_test5,
  input wire logic [5:0] probe_inputs,
  input wire logic [5:0] probe_cal3,
  input wire logic [5:0] probe_digital,
  // temperature levels
  input wire logic [9:0] temp_sense_mv,
  input wire logic [9:0] temp_base_mv,
  // output pins
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe,
  output logic alarm_out,
  output logic alarm_oe,
  output logic line_driver_en,
  output logic polarity_protect_en
);
  import opm_pkg::*;

  logic [3:0] temp_warn_trim;
  logic [3:0] operating_mode;
  logic temp_warn_window;

  // normal position output modes
  function automatic logic opm_is_normal(input logic [3:0] m);
    return (m == OPM_MODE_ABZ) || (m == OPM_MODE_UVW) || (m == OPM_MODE_COUNTER);
  endfunction : opm_is_normal

  // modes with a probe function
  function automatic logic opm_is_probe(input logic [3:0] m);
    return (m == OPM_MODE_CAL1) || (m == OPM_MODE_CAL2) || (m == OPM_MODE_TEST5)
        || (m == OPM_MODE_TEST6) || (m == OPM_MODE_CAL3) || (m == OPM_MODE_SYSTEST);
  endfunction : opm_is_probe

  // {oe[5:0], out[5:0], alarm_oe, alarm_level} for a mode
  function automatic logic [13:0] opm_select(input logic [3:0] m, input logic [5:0] pos,
      input logic [5:0] uvw, input logic [5:0] cnt, input logic [5:0] p1,
      input logic [5:0] p2, input logic [5:0] p5, input logic [5:0] p6,
      input logic [5:0] p7, input logic [5:0] pb, input logic err, input logic ierr,
      input logic twarn);
    logic [13:0] r;
    r = 14'h0000; // reserved codes: nothing driven
    case (m)
      OPM_MODE_ABZ: r = {6'h3F, pos, err, 1'b0};
      OPM_MODE_UVW: r = {6'h3F, uvw, err, 1'b0};
      OPM_MODE_COUNTER: r = {6'h3F, cnt, err, 1'b0};
      OPM_MODE_CAL1: r = {6'h38, p1 & 6'h38, 1'b0, 1'b0};
      OPM_MODE_CAL2: r = {6'h3F, p2, 1'b0, 1'b0};
      OPM_MODE_TEST5: r = {6'h3F, p5, ierr, 1'b0};
      OPM_MODE_TEST6: r = {6'h3F, p6, 1'b0, 1'b0};
      OPM_MODE_CAL3: r = {6'h33, p7 & 6'h33, twarn, 1'b0};
      OPM_MODE_SYSTEST: r = {6'h3F, pb, err, 1'b0};
      default: r = 14'h0000;
    endcase
    return r;
  endfunction : opm_select

  // bit order of the pin vectors: 0 a_pos, 1 a_neg, 2 b_pos, 3 b_neg, 4 z_pos, 5 z_neg
  logic [5:0] abz_pins;
  logic [5:0] uvw_pins;
  logic [5:0] cnt_pins;
  logic [13:0] next_sel;
  logic write_trim;
  logic write_mode;
  logic [7:0] next_rdata;

  assign abz_pins = {~quad_z, quad_z, ~quad_b, quad_b, ~quad_a, quad_a};
  assign uvw_pins = {comm_w, quad_z, comm_v, quad_b, comm_u, quad_a};
  assign cnt_pins = {counter_load_low, counter_clear_high, count_direction_low_up,
                     count_pulse, count_up_pulse, count_down_pulse};
  assign next_sel = opm_select(operating_mode, abz_pins, uvw_pins, cnt_pins, probe_cal1,
                               probe_cal2, probe_test5, probe_inputs, probe_cal3,
                               probe_digital, error_active, internal_error,
                               temp_warn_window);

  // register decode; unmapped reads answer zero
  assign write_trim = cfg_write && (cfg_addr == OPM_ADDR_TRIM);
  assign write_mode = cfg_write && (cfg_addr == OPM_ADDR_MODE);
  assign next_rdata = (cfg_addr == OPM_ADDR_TRIM) ? {4'h0, temp_warn_trim} :
                      (cfg_addr == OPM_ADDR_MODE) ? {4'h0, operating_mode} : 8'h00;

  // configuration registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      temp_warn_trim <= OPM_TRIM_RESET;
      operating_mode <= OPM_MODE_RESET;
    end else begin
      if (write_trim) temp_warn_trim <= cfg_wdata[OPM_FIELD_MSB:OPM_FIELD_LSB];
      if (write_mode) operating_mode <= cfg_wdata[OPM_FIELD_MSB:OPM_FIELD_LSB];
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata <= cfg_read ? next_rdata : 8'h00;
      cfg_rvalid <= cfg_read;
    end
  end

  // registered pins so mode switches never glitch the pads
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_oe <= 6'h00;
      pin_out <= 6'h00;
      alarm_oe <= 1'b0;
      alarm_out <= 1'b0;
      line_driver_en <= 1'b0;
      polarity_protect_en <= 1'b0;
    end else begin
      pin_oe <= next_sel[13:8];
      pin_out <= next_sel[7:2];
      alarm_oe <= next_sel[1]; // open drain: enable pulls low
      alarm_out <= next_sel[0];
      line_driver_en <= opm_is_normal(operating_mode);
      polarity_protect_en <= opm_is_normal(operating_mode);
    end
  end

  // warning window from trimmed threshold
  opm_temp_alarm u_temp_alarm (
    .clock(clock),
    .resetn(resetn),
    .trim(temp_warn_trim),
    .sense_mv(temp_sense_mv),
    .base_mv(temp_base_mv),
    .warn_window(temp_warn_window)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_MODE_WRITE: assert property (write_mode |=> operating_mode == $past(cfg_wdata[3:0]))
    else $error("mode register did not take written value");
  AST_ABZ_PAIR: assert property (
      operating_mode == OPM_MODE_ABZ && $stable(operating_mode)
      |=> pin_out[1] == ~pin_out[0] && pin_out[3] == ~pin_out[2] && pin_out[5] == ~pin_out[4]
      && pin_out[0] == $past(quad_a) && pin_out[2] == $past(quad_b)
      && pin_out[4] == $past(quad_z))
    else $error("abz pairs not complementary");
  AST_UVW_MAP: assert property (
      operating_mode == OPM_MODE_UVW |=> pin_out[1] == $past(comm_u)
      && pin_out[3] == $past(comm_v) && pin_out[5] == $past(comm_w))
    else $error("uvw pins wrong");
  AST_UVW_POS: assert property (
      operating_mode == OPM_MODE_UVW |=> pin_out[0] == $past(quad_a)
      && pin_out[2] == $past(quad_b) && pin_out[4] == $past(quad_z) && pin_oe == 6'h3F)
    else $error("uvw positive pins wrong");
  AST_CNT_MAP: assert property (
      operating_mode == OPM_MODE_COUNTER
      |=> pin_out == $past(cnt_pins) && pin_oe == 6'h3F)
    else $error("counter pins wrong");
  AST_DRV_NORMAL: assert property (
      opm_is_normal(operating_mode)
      |=> line_driver_en && polarity_protect_en)
    else $error("drivers off in normal mode");
  AST_DRV_PROBE: assert property (
      opm_is_probe(operating_mode)
      |=> !line_driver_en && !polarity_protect_en)
    else $error("drivers on in probe mode");
  AST_CAL1_PROBE: assert property (
      operating_mode == OPM_MODE_CAL1
      |=> pin_oe == 6'h38 && pin_out[3] == $past(probe_cal1[3]) && !alarm_oe)
    else $error("calibration 1 routing wrong");
  AST_TEST5_ERR: assert property (
      operating_mode == OPM_MODE_TEST5
      |=> alarm_oe == $past(internal_error) && pin_out == $past(probe_test5))
    else $error("test 5 routing wrong");
  AST_CAL3_TEMP: assert property (
      operating_mode == OPM_MODE_CAL3
      |=> pin_out[1:0] == $past(probe_cal3[1:0]) && alarm_oe == $past(temp_warn_window)
      && !alarm_out)
    else $error("temperature calibration routing wrong");
  AST_RESERVED: assert property (
      !opm_is_normal(operating_mode) && !opm_is_probe(operating_mode)
      |=> pin_oe == 6'h00 && !alarm_oe && !line_driver_en)
    else $error("reserved mode drives pins");
  AST_READ_MODE: assert property (
      cfg_read && cfg_addr == OPM_ADDR_MODE
      |=> cfg_rvalid && cfg_rdata == {4'h0, $past(operating_mode)})
    else $error("mode read answer wrong");
  AST_ALARM_LEVEL: assert property (alarm_oe |-> !alarm_out)
    else $error("alarm pin driven high");
endmodule : opm_output_mux
`default_nettype wire

// file: dv/opm_line_receiver.sv
// Purpose: line receiver and alarm pull-up seen at the block's pins
// Assumes: undriven lines float; the alarm pin has an external pull-up
// Notes: floating lines toggle every cycle so a stale level never matches
`default_nettype none
module opm_line_receiver (
  // clock
  input wire logic clock,
  // pins from the block
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic alarm_out,
  input wire logic alarm_oe,
  // levels seen on the wires
  output logic [5:0] line,
  output logic alarm_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] float_pat = 6'h15;
  // floating pattern, flipped every cycle
  always @(posedge clock) float_pat <= ~float_pat;
  // each wire follows its pin only while enabled
  assign line = (pin_oe & pin_out) | (~pin_oe & float_pat);
  assign alarm_line = alarm_oe ? alarm_out : 1'b1; // pull-up when released
endmodule : opm_line_receiver
`default_nettype wire

// file: dv/testbench.sv
// Purpose: self-checking bench for the output mode pin multiplexer
// Assumes: host has preset alarm mask, shortest alarm time, active-low
// Notes: expectations queued by the driver, compared by a monitor
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import opm_pkg::*;
  typedef struct packed {logic [5:0] out, mask, oe; logic al, drv;} opm_exp_type;
  logic clock = 0, resetn = 0, cfg_write = 0, cfg_read = 0, pin_chk = 0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, ra = 8'h00, rb = 8'h00, seed = 8'h06;
  logic [9:0] sense = 10'h0258;
  logic [7:0] cfg_rdata;
  logic [5:0] pin_out, pin_oe, line;
  logic cfg_rvalid, alarm_out, alarm_oe, line_driver_en, polarity_protect_en, alarm_line;
  logic [7:0] rd_q[$];
  opm_exp_type pin_q[$];
  int n_errors = 0, n_tests = 0, cycles = 0, thr;
  int offs[4] = '{0, 25, 26, -1};
  always #4 clock = ~clock;
  opm_output_mux opm_output_mux_inst (.clock(clock), .resetn(resetn), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .quad_a(ra[0]), .quad_b(ra[1]), .quad_z(ra[2]), .comm_u(ra[3]),
    .comm_v(ra[4]), .comm_w(ra[5]), .count_down_pulse(rb[0]), .count_up_pulse(rb[1]),
    .count_pulse(rb[2]), .count_direction_low_up(rb[3]), .counter_clear_high(rb[4]),
    .counter_load_low(rb[5]), .error_active(ra[6]), .internal_error(ra[7]),
    .probe_cal1(rb[5:0]), .probe_cal2(~rb[5:0]), .probe_test5(ra[5:0]),
    .probe_inputs(~ra[5:0]), .probe_cal3(rb[5:0]), .probe_digital({ra[2:0], rb[2:0]}),
    .temp_sense_mv(sense), .temp_base_mv(10'h012C), .pin_out(pin_out), .pin_oe(pin_oe),
    .alarm_out(alarm_out), .alarm_oe(alarm_oe), .line_driver_en(line_driver_en),
    .polarity_protect_en(polarity_protect_en));
  opm_line_receiver opm_line_receiver_inst (.clock(clock), .pin_out(pin_out),
    .pin_oe(pin_oe), .alarm_out(alarm_out), .alarm_oe(alarm_oe), .line(line),
    .alarm_line(alarm_line));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // expected pins per mode; cal3 analog pins are not compared
  function automatic opm_exp_type model(input logic [3:0] m, input logic al_t);
    opm_exp_type e;
    logic nrm;
    nrm = (m == OPM_MODE_ABZ) || (m == OPM_MODE_UVW) || (m == OPM_MODE_COUNTER);
    e = '{out: 6'h00, mask: 6'h00, oe: 6'h3F, al: 1'b0, drv: nrm};
    case (m)
      OPM_MODE_ABZ: e.out = {~ra[2], ra[2], ~ra[1], ra[1], ~ra[0], ra[0]};
      OPM_MODE_UVW: e.out = {ra[5], ra[2], ra[4], ra[1], ra[3], ra[0]};
      OPM_MODE_COUNTER: e.out = rb[5:0];
      OPM_MODE_CAL1: e.oe = 6'h38;
      OPM_MODE_CAL2: e.out = ~rb[5:0];
      OPM_MODE_TEST5: e.out = ra[5:0];
      OPM_MODE_TEST6: e.out = ~ra[5:0];
      OPM_MODE_CAL3: e.oe = 6'h33;
      OPM_MODE_SYSTEST: e.out = {ra[2:0], rb[2:0]};
      default: e.oe = 6'h00;
    endcase
    if (m == OPM_MODE_CAL1) e.out = rb[5:0] & 6'h38;
    e.mask = (m == OPM_MODE_CAL3) ? 6'h00 : e.oe;
    e.out = e.out & e.mask;
    e.al = (nrm || m == OPM_MODE_SYSTEST) ? ra[6] : (m == OPM_MODE_TEST5) ? ra[7] :
      (m == OPM_MODE_CAL3) ? al_t : 1'b0;
    return e;
  endfunction : model
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_write <= 1'b1;
    @(posedge clock);
    cfg_write <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clock);
    cfg_addr <= a;
    cfg_read <= 1'b1;
    @(posedge clock);
    cfg_read <= 1'b0;
  endtask : rd
  // let sources settle through the register stage, then ask for a compare
  task check(input logic [3:0] m, input logic al_t);
    repeat (3) @(posedge clock);
    pin_q.push_back(model(m, al_t));
    pin_chk <= 1'b1;
    @(posedge clock);
    pin_chk <= 1'b0;
  endtask : check
  task fail(input string msg);
    n_errors++;
    $display("Error %0t %s", $time, msg);
  endtask : fail
  task cmp_rd();
    logic [7:0] e;
    e = rd_q.pop_front();
    n_tests++;
    if (cfg_rdata !== e) fail($sformatf("read %h expected %h", cfg_rdata, e));
  endtask : cmp_rd
  task cmp_pin();
    opm_exp_type e, g;
    e = pin_q.pop_front();
    g = '{out: line & e.mask, mask: e.mask, oe: pin_oe, al: ~alarm_line, drv: line_driver_en};
    n_tests++;
    if (g !== e || polarity_protect_en !== e.drv) fail($sformatf("pins %h expected %h", g, e));
  endtask : cmp_pin
  // monitor: one queued note per result
  always @(negedge clock) begin
    if (cfg_rvalid === 1'b1) cmp_rd();
    if (pin_chk) cmp_pin();
  end
  task wrap_up();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // cut a hang short; the full run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    rd(OPM_ADDR_TRIM, 8'h00);
    rd(OPM_ADDR_MODE, 8'h00);
    rd(8'h00, 8'h00);
    wr(OPM_ADDR_MODE, 8'hFF);
    rd(OPM_ADDR_MODE, 8'h0F);
    // a write to an unmapped address must leave the mode alone
    wr(8'h03, 8'h05);
    rd(OPM_ADDR_MODE, 8'h0F);
    // every code, several random source patterns each
    for (int m = 0; m < 16; m++) begin
      wr(OPM_ADDR_MODE, 8'(m));
      for (int k = 0; k < 3; k++) begin
        seed = lfsr(seed);
        ra <= seed;
        seed = lfsr(seed);
        rb <= seed;
        check(4'(m), 1'b0);
      end
      rd(OPM_ADDR_MODE, 8'(m));
    end
    // temperature window edges; alarm settings taken as preset
    wr(OPM_ADDR_MODE, 8'h07);
    for (int t = 0; t < 16; t += 7) begin
      wr(OPM_ADDR_TRIM, 8'(t));
      rd(OPM_ADDR_TRIM, 8'(t));
      thr = 3 * (100 + 5 * t);
      for (int d = 0; d < 4; d++) begin
        sense <= 10'(thr - offs[d]);
        check(OPM_MODE_CAL3, d < 2);
      end
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
